// ### rtl/cbs_pkg.sv
package cbs_pkg;
   // one device clock is two system clocks, giving half-clock resolution
   localparam int          DEV_CLK_TICKS = 2;
   localparam int          CYC_CLKS      = 8;
   localparam int          CYC_TICKS     = CYC_CLKS * DEV_CLK_TICKS;
   localparam logic [3:0]  TICK_LAST     = 4'(CYC_TICKS - 1);
   localparam logic [3:0]  TPA_T0        = 4'h2;
   localparam logic [3:0]  TPA_T1        = 4'h3;
   localparam logic [3:0]  Q_T           = 4'h4;
   localparam logic [3:0]  ADDR_LO_T     = 4'h5;
   localparam logic [3:0]  EMS_T0        = 4'h7;
   localparam logic [3:0]  INT_DATA_T    = 4'h7;
   localparam logic [3:0]  MWR_T0        = 4'ha;
   localparam logic [3:0]  MWR_T1        = 4'hd;
   localparam logic [3:0]  TPB_T0        = 4'he;
   localparam logic [3:0]  ME_SAMPLE_T   = 4'he;
   localparam logic [3:0]  INTR_X        = 4'h2;
   localparam logic [3:0]  INTR_P        = 4'h1;
   localparam logic [3:0]  OP_IO         = 4'h6;
   localparam logic [3:0]  OP_MISC       = 4'h7;
   localparam logic [4:0]  ROM_BLOCK_RST = 5'h00;
   localparam logic [9:0]  RAM_BLOCK_RST = 10'h3ff;

   typedef enum logic [1:0] {
      ST_FETCH = 2'b00,
      ST_EXEC  = 2'b01,
      ST_DMA   = 2'b10,
      ST_INTR  = 2'b11
   } cbs_state_t;

   // code is {clear, wait}
   typedef enum logic [1:0] {
      MODE_ROMRAM  = 2'b00,
      MODE_RESET   = 2'b01,
      MODE_PAUSE   = 2'b10,
      MODE_RAMONLY = 2'b11
   } cbs_mode_t;
endpackage

// ### rtl/cbs_sync.sv
`timescale 1ns/100ps
module cbs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ### rtl/cbs_int_mem.sv
`timescale 1ns/100ps
module cbs_int_mem #(
   parameter int         RAM_DEPTH = 64,
   parameter logic [7:0] ROM_FILL  = 8'h00
) (
   input  wire logic        clk,
   input  wire logic        ram_we,
   input  wire logic        rom_sel,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0] ram_r [RAM_DEPTH];

   // rom body is a blank mask until contents are defined
   always_comb begin
      rdata = rom_sel ? ROM_FILL : ram_r[addr[$clog2(RAM_DEPTH)-1:0]];
   end

   always_ff @(posedge clk) begin
      if (ram_we) begin
         ram_r[addr[$clog2(RAM_DEPTH)-1:0]] <= wdata;
      end
   end
endmodule

// ### rtl/cbs_seq.sv
`timescale 1ns/100ps
module cbs_seq
   import cbs_pkg::*;
#(
   parameter logic [4:0] ROM_BLOCK = ROM_BLOCK_RST,
   parameter logic [9:0] RAM_BLOCK = RAM_BLOCK_RST
) (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clear_in,
   input  wire logic       wait_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   input  wire logic       flag_input_1,
   input  wire logic       flag_input_2,
   input  wire logic       flag_input_3,
   input  wire logic       flag_input_4,
   input  wire logic       irq_req_n,
   input  wire logic       dma_in_req_n,
   input  wire logic       dma_out_req_n,
   input  wire logic       internal_ram_select_n,
   output logic            expansion_memory_select_n,
   output logic            mem_select_oe,
   input  wire logic       counter_underflow,
   input  wire logic       toggle_enable_instr,
   input  wire logic       load_counter_instr,
   input  wire logic       branch_on_counter_irq,
   output logic [7:0]      multiplexed_address_line,
   output logic            address_strobe_pulse,
   output logic            data_strobe_pulse,
   output logic            state_code_low,
   output logic            state_code_high,
   output logic            read_level_n,
   output logic            write_pulse_n,
   output logic            io_command_line_0,
   output logic            io_command_line_1,
   output logic            io_command_line_2,
   output logic            q_out,
   output logic [3:0]      flags_sampled,
   output logic            master_irq_enable
);
   cbs_state_t  state_r;
   cbs_mode_t   mode;
   logic [3:0]  tick_r;
   logic [15:0] regs_r [16];
   logic [3:0]  p_r, x_r, n_r, i_r;
   logic [7:0]  t_r, lat_r;
   logic        toggle_r, dma_in_s_r, dma_out_s_r, irq_s_r, dma_out_cyc_r;
   logic [1:0]  ctl_s;
   logic [7:0]  data_s;
   logic [3:0]  flag_s;
   logic [3:0]  req_s;
   logic        advance, cyc_end, soft_rst, romram;
   logic        cyc_read, cyc_write, int_hit, rom_hit, ram_sel, ram_we;
   logic [15:0] cur_addr;
   logic [7:0]  int_rdata;

   function automatic logic is_io(input logic [3:0] i, input logic [3:0] n);
      return i == OP_IO && n[2:0] != 3'h0;
   endfunction

   function automatic logic is_ret(input logic [3:0] i, input logic [3:0] n);
      return i == OP_MISC && n[3:1] == 3'b000;
   endfunction

   function automatic logic is_seq(input logic [3:0] i, input logic [3:0] n);
      return i == OP_MISC && n[3:1] == 3'b101;
   endfunction

   cbs_sync #(.W(2)) u_ctl_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({clear_in, wait_in}),
      .q       (ctl_s)
   );

   cbs_sync #(.W(8)) u_data_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       (data_in),
      .q       (data_s)
   );

   cbs_sync #(.W(8)) u_pin_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({flag_input_4, flag_input_3, flag_input_2, flag_input_1,
                 internal_ram_select_n, irq_req_n, dma_out_req_n, dma_in_req_n}),
      .q       ({flag_s, req_s})
   );

   cbs_int_mem u_mem (
      .clk     (clk),
      .ram_we  (ram_we),
      .rom_sel (rom_hit),
      .addr    (cur_addr),
      .wdata   (data_s),
      .rdata   (int_rdata)
   );

   always_comb begin
      mode     = cbs_mode_t'(ctl_s);
      romram   = mode == MODE_ROMRAM;
      soft_rst = sys_rst || mode == MODE_RESET;
      // freeze just after a strobe has risen, so the strobe stays high while paused
      advance  = !(mode == MODE_PAUSE
                   && (tick_r == 4'(TPA_T0 + 4'h1) || tick_r == 4'(TPB_T0 + 4'h1)));
      cyc_end  = advance && tick_r == TICK_LAST;
      case (state_r)
         ST_FETCH: cur_addr = regs_r[p_r];
         ST_DMA:   cur_addr = regs_r[0];
         default:  cur_addr = regs_r[x_r];
      endcase
      cyc_read  = state_r == ST_FETCH
               || (state_r == ST_DMA && dma_out_cyc_r)
               || (state_r == ST_EXEC && ((is_io(i_r, n_r) && !n_r[3]) || is_ret(i_r, n_r)));
      cyc_write = (state_r == ST_DMA && !dma_out_cyc_r)
               || (state_r == ST_EXEC && is_io(i_r, n_r) && n_r[3]);
      rom_hit   = romram && cur_addr[15:11] == ROM_BLOCK && cyc_read;
      // ram-only: no internal decode, the select pin alone picks the ram
      ram_sel   = romram ? cur_addr[15:6] == RAM_BLOCK : !req_s[3];
      int_hit   = (cyc_read || cyc_write) && (rom_hit || ram_sel);
      ram_we    = advance && tick_r == ME_SAMPLE_T && cyc_write && ram_sel && !rom_hit;
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         tick_r <= 4'h0;
      end else if (advance) begin
         tick_r <= 4'(tick_r + 4'h1);
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         state_r       <= ST_FETCH;
         dma_out_cyc_r <= 1'b0;
      end else if (cyc_end) begin
         case (state_r)
            ST_FETCH: state_r <= ST_EXEC;
            ST_EXEC, ST_DMA: begin
               if (dma_in_s_r || dma_out_s_r) begin
                  state_r <= ST_DMA;
               end else if (irq_s_r && master_irq_enable) begin
                  state_r <= ST_INTR;
               end else begin
                  state_r <= ST_FETCH;
               end
            end
            ST_INTR: state_r <= (dma_in_s_r || dma_out_s_r) ? ST_DMA : ST_FETCH;
            default: state_r <= ST_FETCH;
         endcase
         dma_out_cyc_r <= !dma_in_s_r;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         dma_in_s_r  <= 1'b0;
         dma_out_s_r <= 1'b0;
         irq_s_r     <= 1'b0;
      end else if (advance && tick_r == TPB_T0 && state_r != ST_FETCH) begin
         dma_in_s_r  <= !req_s[0];
         dma_out_s_r <= !req_s[1];
         if (state_r != ST_INTR) begin
            irq_s_r <= !req_s[2];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         lat_r <= 8'h00;
         i_r   <= 4'h0;
         n_r   <= 4'h0;
      end else if (advance && tick_r == TPB_T0) begin
         lat_r <= int_hit ? int_rdata : data_s;
         if (state_r == ST_FETCH) begin
            {i_r, n_r} <= int_hit ? int_rdata : data_s;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         flags_sampled <= 4'h0;
      end else if (cyc_end && state_r == ST_FETCH) begin
         flags_sampled <= flag_s;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         for (int k = 0; k < 16; k++) begin
            regs_r[k] <= 16'h0000;
         end
      end else if (cyc_end) begin
         if (state_r == ST_FETCH) begin
            regs_r[p_r] <= 16'(regs_r[p_r] + 16'h0001);
         end else if (state_r == ST_DMA) begin
            regs_r[0] <= 16'(regs_r[0] + 16'h0001);
         end else if (state_r == ST_EXEC && (is_io(i_r, n_r) || is_ret(i_r, n_r))) begin
            regs_r[x_r] <= 16'(regs_r[x_r] + 16'h0001);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         p_r               <= 4'h0;
         x_r               <= 4'h0;
         t_r               <= 8'h00;
         master_irq_enable <= 1'b1;
      end else if (cyc_end && state_r == ST_INTR) begin
         t_r               <= {x_r, p_r};
         x_r               <= INTR_X;
         p_r               <= INTR_P;
         master_irq_enable <= 1'b0;
      end else if (cyc_end && state_r == ST_EXEC && is_ret(i_r, n_r)) begin
         {x_r, p_r}        <= lat_r;
         master_irq_enable <= !n_r[0];
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         toggle_r <= 1'b0;
      end else if (toggle_enable_instr) begin
         toggle_r <= 1'b1;
      end else if (load_counter_instr || branch_on_counter_irq) begin
         toggle_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         q_out <= 1'b0;
      end else if (advance && tick_r == Q_T && state_r == ST_EXEC && is_seq(i_r, n_r)) begin
         q_out <= n_r[0];
      end else if (toggle_r && counter_underflow) begin
         q_out <= !q_out;
      end
   end

   // outputs are decoded from the tick and land one system clock later
   always_ff @(posedge clk) begin
      if (soft_rst) begin
         multiplexed_address_line  <= 8'h00;
         address_strobe_pulse      <= 1'b0;
         data_strobe_pulse         <= 1'b0;
         state_code_low            <= 1'b0;
         state_code_high           <= 1'b0;
         read_level_n              <= 1'b1;
         write_pulse_n             <= 1'b1;
         {io_command_line_2, io_command_line_1, io_command_line_0} <= 3'h0;
         expansion_memory_select_n <= 1'b1;
         mem_select_oe             <= 1'b0;
         data_out                  <= 8'h00;
         data_oe                   <= 1'b0;
      end else if (advance) begin
         multiplexed_address_line  <= tick_r < ADDR_LO_T ? cur_addr[15:8] : cur_addr[7:0];
         address_strobe_pulse      <= tick_r >= TPA_T0 && tick_r <= TPA_T1;
         data_strobe_pulse         <= tick_r >= TPB_T0;
         {state_code_high, state_code_low} <= state_r;
         read_level_n              <= !cyc_read;
         write_pulse_n             <= !(cyc_write && tick_r >= MWR_T0 && tick_r <= MWR_T1);
         {io_command_line_2, io_command_line_1, io_command_line_0} <=
            (state_r == ST_EXEC && is_io(i_r, n_r)) ? n_r[2:0] : 3'h0;
         expansion_memory_select_n <= !(romram && (cyc_read || cyc_write) && !int_hit
                                      && tick_r >= EMS_T0);
         mem_select_oe             <= romram;
         data_out                  <= int_rdata;
         data_oe                   <= cyc_read && int_hit && tick_r >= INT_DATA_T;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (soft_rst);

   cycle_eight_a: assert property (
      disable iff (soft_rst || mode == MODE_PAUSE)
      $rose(address_strobe_pulse) |-> ##16 $rose(address_strobe_pulse))
      else $error("machine cycle not sixteen system clocks");
   state_code_a: assert property (
      $rose(address_strobe_pulse) |-> {state_code_high, state_code_low} == state_r)
      else $error("state code wrong at address strobe");
   io_lines_low_a: assert property (
      {state_code_high, state_code_low} != ST_EXEC
      |-> {io_command_line_2, io_command_line_1, io_command_line_0} == 3'h0)
      else $error("io command lines active outside execute");
   io_direction_a: assert property (
      {io_command_line_2, io_command_line_1, io_command_line_0} != 3'h0
      |-> read_level_n == n_r[3])
      else $error("read level does not follow io direction");
   flag_sample_a: assert property (
      (cyc_end && state_r == ST_FETCH) |=> flags_sampled == $past(flag_s))
      else $error("flags not sampled at fetch end");
   intr_entry_a: assert property (
      (cyc_end && state_r == ST_INTR)
      |=> p_r == INTR_P && x_r == INTR_X && !master_irq_enable && t_r == $past({x_r, p_r}))
      else $error("interrupt entry wrong");
   dma_incr_a: assert property (
      (cyc_end && state_r == ST_DMA) |=> regs_r[0] == 16'($past(regs_r[0]) + 16'h0001))
      else $error("dma pointer not incremented");
   dma_priority_a: assert property (
      (cyc_end && state_r == ST_EXEC && dma_in_s_r) |=> state_r == ST_DMA && !dma_out_cyc_r)
      else $error("dma in not served first");
   write_stable_a: assert property (
      !write_pulse_n |-> $stable(multiplexed_address_line) && !address_strobe_pulse)
      else $error("write pulse while address moving");
   q_window_a: assert property (
      ($changed(q_out) && !toggle_r) |-> tick_r == 4'(Q_T + 4'h1))
      else $error("output flag changed outside strobe window");
   ems_window_a: assert property (
      !expansion_memory_select_n
      |-> romram && !address_strobe_pulse && !data_oe && $past(cyc_read || cyc_write))
      else $error("expansion select outside external access");

   intr_seen_c: cover property (cyc_end && state_r == ST_INTR);
   dma_seen_c:  cover property (cyc_end && state_r == ST_DMA && dma_out_cyc_r);
   pause_c:     cover property (!advance [*4] ##1 advance);
endmodule

// ### sim/cbs_mem_model.sv
`timescale 1ns/100ps
module cbs_mem_model #(
   parameter logic [9:0] RAM_BASE = 10'h3ff
) (
   input  wire logic       clk,
   input  wire logic       read_level_n,
   input  wire logic       address_strobe_pulse,
   input  wire logic [7:0] multiplexed_address_line,
   output logic      [7:0] data_in,
   output logic            ram_sel_n
);
   logic [7:0] mem [256];
   logic [7:0] hi_r;
   logic       strobe_r;
   logic       int_hit;

   initial begin
      data_in  = 8'h00;
      hi_r     = 8'h00;
      strobe_r = 1'b0;
   end

   // high byte taken on the falling address strobe
   always @(posedge clk) begin
      strobe_r <= address_strobe_pulse;
      if (strobe_r && !address_strobe_pulse) begin
         hi_r <= multiplexed_address_line;
      end
   end

   // external decode of the internal ram block, high for every external access
   assign int_hit   = ({hi_r, multiplexed_address_line[7:6]} == RAM_BASE);
   assign ram_sel_n = !int_hit;

   // released bus shows a changing pattern rather than the last byte
   always @(posedge clk) begin
      if (!read_level_n && !int_hit) begin
         data_in <= mem[multiplexed_address_line];
      end else begin
         data_in <= ~data_in;
      end
   end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top import cbs_pkg::*;;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       clear_in = 1'b1;
   logic       wait_in = 1'b1;
   logic [3:0] flg = 4'h0;
   logic       irq_n = 1'b1;
   logic       dmai_n = 1'b1;
   logic       dmao_n = 1'b1;
   logic       unf = 1'b0;
   logic       tog = 1'b0;
   logic       ld_p = 1'b0;
   logic       br_p = 1'b0;
   logic [7:0] data_in, data_out, mal;
   logic       data_oe, xsel_n, sel_oe, mdl_sel_n, ram_sel_w, as_p, ds_p, sc_l, sc_h;
   logic       rd_n, wr_n, io0, io1, io2, q_out, irq_en;
   logic [3:0] flags_s;
   int         fail_count = 0;
   int         n_compared = 0;
   logic [1:0] c_st;
   logic [7:0] c_hi, c_lo;
   logic [2:0] c_io;
   logic       c_rd, c_q3, c_q7, c_oe7, c_xs;
   int         c_wr, c_gap;

   always #4 clk = ~clk;
   assign ram_sel_w = sel_oe ? xsel_n : mdl_sel_n;

   cbs_seq uut (
      .clk(clk), .sys_rst(sys_rst), .clear_in(clear_in), .wait_in(wait_in), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .flag_input_1(flg[0]), .flag_input_2(flg[1]),
      .flag_input_3(flg[2]), .flag_input_4(flg[3]), .irq_req_n(irq_n), .dma_in_req_n(dmai_n),
      .dma_out_req_n(dmao_n), .internal_ram_select_n(ram_sel_w),
      .expansion_memory_select_n(xsel_n), .mem_select_oe(sel_oe), .counter_underflow(unf),
      .toggle_enable_instr(tog), .load_counter_instr(ld_p), .branch_on_counter_irq(br_p),
      .multiplexed_address_line(mal), .address_strobe_pulse(as_p), .data_strobe_pulse(ds_p),
      .state_code_low(sc_l), .state_code_high(sc_h), .read_level_n(rd_n),
      .write_pulse_n(wr_n), .io_command_line_0(io0), .io_command_line_1(io1),
      .io_command_line_2(io2), .q_out(q_out), .flags_sampled(flags_s),
      .master_irq_enable(irq_en)
   );

   cbs_mem_model u_mem (
      .clk(clk), .read_level_n(rd_n), .address_strobe_pulse(as_p),
      .multiplexed_address_line(mal), .data_in(data_in), .ram_sel_n(mdl_sel_n)
   );

   task automatic summarize();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task automatic fill(input logic [7:0] v);
      for (int i = 0; i < 256; i++) begin
         u_mem.mem[i] = v;
      end
   endtask

   // one machine cycle seen from the pins, returns at the data strobe
   task automatic cyc();
      int   n;
      logic p;
      n = 0;
      do begin
         p = as_p;
         @(negedge clk);
         n++;
         if (n > 64) begin
            chk(1'b0, "no address strobe");
            summarize();
         end
      end while (!(p === 1'b0 && as_p === 1'b1));
      c_gap = n;
      c_st = {sc_h, sc_l};
      c_hi = mal;
      c_rd = rd_n;
      c_q3 = q_out;
      c_wr = 0;
      repeat (3) @(negedge clk);
      c_lo = mal;
      c_io = {io2, io1, io0};
      c_q7 = q_out;
      c_oe7 = data_oe;
      c_xs = xsel_n;
      repeat (9) begin
         @(negedge clk);
         c_wr += (wr_n === 1'b0);
      end
   endtask

   task automatic to_fetch();
      int k;
      k = 0;
      do begin
         cyc();
         k++;
      end while (c_st !== ST_FETCH && k < 8);
      chk(c_st === ST_FETCH, "fetch not reached");
   endtask

   task automatic pl(input logic [3:0] k);
      @(negedge clk);
      {unf, tog, ld_p, br_p} = k;
      @(negedge clk);
      {unf, tog, ld_p, br_p} = 4'h0;
      repeat (3) @(negedge clk);
   endtask

   task automatic t_cycle();
      logic [7:0] lo0;
      fill(8'hc4);
      to_fetch();
      lo0 = c_lo;
      chk(c_hi === 8'h00 && c_rd === 1'b0 && sel_oe === 1'b0, "fetch read");
      cyc();
      chk(c_st === ST_EXEC && c_gap == 4, "exec after fetch");
      cyc();
      chk(c_st === ST_FETCH && c_lo === lo0 + 8'h01, "fetch address step");
      chk(ds_p === 1'b1 && as_p === 1'b0, "data strobe at cycle end");
   endtask

   task automatic t_flags(input logic [3:0] f);
      flg = f;
      repeat (3) cyc();
      chk(flags_s === f, "flag sample");
   endtask

   task automatic t_q(input logic [7:0] op, input logic qb, input logic qa);
      fill(op);
      to_fetch();
      cyc();
      chk(c_st === ST_EXEC && c_q3 === qb && c_q7 === qa, "flag output step");
   endtask

   task automatic t_io(input logic [7:0] op, input logic [2:0] io, input logic rd, int wr);
      fill(op);
      to_fetch();
      chk(c_io === 3'b000, "command lines idle");
      cyc();
      chk(c_st === ST_EXEC && c_io === io, "command lines");
      chk(c_rd === rd && c_wr == wr, "io direction");
   endtask

   task automatic t_toggle();
      logic qa;
      qa = q_out;
      pl(4'h4);
      pl(4'h8);
      chk(q_out === ~qa, "toggle flip");
      pl(4'h2);
      pl(4'h8);
      chk(q_out === ~qa, "toggle cleared by load");
      pl(4'h4);
      pl(4'h1);
      pl(4'h8);
      chk(q_out === ~qa, "toggle cleared by branch");
   endtask

   task automatic t_dma();
      logic [7:0] lo0;
      int         k;
      fill(8'hc4);
      irq_n = 1'b0;
      dmai_n = 1'b0;
      dmao_n = 1'b0;
      k = 0;
      do begin
         cyc();
         k++;
      end while ((c_st === ST_FETCH || c_st === ST_EXEC) && k < 6);
      chk(c_st === ST_DMA && c_wr == 4, "dma-in first");
      lo0 = c_lo;
      cyc();
      chk(c_st === ST_DMA && c_lo === lo0 + 8'h01, "dma pointer step");
      dmai_n = 1'b1;
      k = 0;
      do begin
         cyc();
         k++;
      end while (!(c_st === ST_DMA && c_wr == 0) && k < 4);
      chk(c_st === ST_DMA && c_wr == 0 && c_rd === 1'b0, "dma-out next");
      dmao_n = 1'b1;
      k = 0;
      do begin
         cyc();
         k++;
      end while (c_st === ST_DMA && k < 4);
      chk(c_st === ST_INTR, "interrupt after dma");
      cyc();
      chk(c_st === ST_FETCH && {c_hi, c_lo} === 16'h0000 && irq_en === 1'b0, "irq entry");
      repeat (4) begin
         cyc();
         chk(c_st !== ST_INTR, "irq while disabled");
      end
      irq_n = 1'b1;
   endtask

   task automatic t_mode();
      logic [13:0] snap;
      int          k;
      clear_in = 1'b1;
      wait_in = 1'b0;
      repeat (40) @(negedge clk);
      snap = {as_p, ds_p, mal, sc_h, sc_l, rd_n, wr_n};
      chk(as_p === 1'b1 || ds_p === 1'b1, "pause at strobe");
      repeat (20) @(negedge clk);
      chk(snap === {as_p, ds_p, mal, sc_h, sc_l, rd_n, wr_n}, "pause holds");
      wait_in = 1'b1;
      cyc();
      chk(c_gap < 20, "resume after pause");
      pl(4'h4);
      clear_in = 1'b0;
      repeat (8) @(negedge clk);
      chk({sc_h, sc_l} === 2'b00 && as_p === 1'b0 && irq_en === 1'b1, "reset mode");
      clear_in = 1'b1;
      cyc();
      pl(4'h8);
      chk(q_out === 1'b0, "toggle cleared by reset");
      wait_in = 1'b0;
      clear_in = 1'b0;
      to_fetch();
      chk(sel_oe === 1'b1 && xsel_n === 1'b1, "select pin output");
      chk(c_oe7 === 1'b0 && data_oe === 1'b1 && data_out === 8'h00, "internal read");
      dmai_n = 1'b0;
      k = 0;
      do begin
         cyc();
         k++;
      end while (c_st !== ST_DMA && k < 6);
      chk(c_st === ST_DMA && c_wr == 4 && c_xs === 1'b1 && xsel_n === 1'b0, "external select");
      dmai_n = 1'b1;
   endtask

   initial begin
      fill(8'hc4);
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      t_cycle();
      t_flags(4'ha);
      t_flags(4'h5);
      t_q(8'h7b, 1'b0, 1'b1);
      t_q(8'h7a, 1'b1, 1'b0);
      t_io(8'h61, 3'b001, 1'b0, 0);
      t_io(8'h6a, 3'b010, 1'b1, 4);
      fill(8'hc4);
      t_toggle();
      t_dma();
      t_mode();
      summarize();
   end
endmodule
